// *** ascii_read_pkg.sv ***
// constants, types and helpers for the ascii individual-read parser
//
// Contract
// - command letter R/r is case-sensitive; every other letter matches either case.
// - each device name starts with percent 25H before area letter and type marker.
// - type marker 58H selects bit, 42H byte, 57H word.
// - timer and counter accept bit, byte, word; word returns current count.
// - bit access to timer or counter returns its contact state.
// - data register and step relay areas reject bit-typed names.
// - byte-typed address is twice the word address; halve it for the word.
// - one request names up to sixteen locations, one per block.
// - block count is two hex characters, 01 to 10 hex.
// - name length is two hex characters, 01 to 10 hex; the code rejects lengths below 04 hex with E_NAME, or with E_TYPE for a bit-typed D or S name.
// - name characters limited to digits, letters and percent; others rejected.
// - lowercase command adds checksum: low byte of sum start through end code.
// - request order: start, station, command, type SS, count, blocks, end, checksum.
// - ACK echoes station, command, type, count; blocks carry byte count and hex data.
// - request begins with 05 hex and ends with 04 hex before checksum.
// - response ends with 03 hex before its checksum.
// - abnormal request answered by NAK carrying four-character ASCII error code.
`default_nettype none
package ascii_read_pkg;
   // ---------------------------------------------------------------
   // control and marker codes
   // ---------------------------------------------------------------
   localparam logic [7:0] C_ENQ = 8'h05;
   localparam logic [7:0] C_EOT = 8'h04;
   localparam logic [7:0] C_ACK = 8'h06;
   localparam logic [7:0] C_NAK = 8'h15;
   localparam logic [7:0] C_ETX = 8'h03;
   localparam logic [7:0] C_PCT = 8'h25;
   localparam logic [7:0] C_BIT = 8'h58;
   localparam logic [7:0] C_BYTE = 8'h42;
   localparam logic [7:0] C_WORD = 8'h57;
   localparam logic [7:0] C_CMD_UP = 8'h52;
   localparam logic [7:0] C_CMD_LO = 8'h72;
   localparam logic [7:0] C_TYPE = 8'h53;
   localparam logic [7:0] C_ZERO = 8'h30;
   // ---------------------------------------------------------------
   // limits and error codes (sent as four hex characters)
   // ---------------------------------------------------------------
   localparam logic [4:0] MAX_BLK = 5'h10;
   localparam logic [4:0] MAX_NAME = 5'h10;
   localparam logic [4:0] MIN_NAME = 5'h04;
   localparam logic [8:0] MAX_FRAME = 9'h100;
   localparam logic [15:0] E_NONE = 16'h0000;
   localparam logic [15:0] E_HEX = 16'h0001;
   localparam logic [15:0] E_CMD = 16'h0002;
   localparam logic [15:0] E_CNT = 16'h0003;
   localparam logic [15:0] E_LEN = 16'h0004;
   localparam logic [15:0] E_NAME = 16'h0005;
   localparam logic [15:0] E_TYPE = 16'h0006;
   localparam logic [15:0] E_FRM = 16'h0007;
   localparam logic [15:0] E_BCC = 16'h0008;
   localparam logic [15:0] E_LONG = 16'h0009;
   // ---------------------------------------------------------------
   // device areas, access widths, request carrier
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {A_P, A_M, A_L, A_K, A_C, A_T, A_D, A_S, A_F} area_t;
   typedef enum logic [1:0] {W_BIT, W_BYTE, W_WORD} width_t;
   typedef struct packed {
      area_t area;
      width_t width;
      logic [15:0] addr;
   } dev_t;
   // fold lower-case letters to upper case
   function automatic logic [7:0] upc(input logic [7:0] b);
      upc = (b >= 8'h61 && b <= 8'h7A) ? b - 8'h20 : b;
   endfunction
   // ascii hex digit to {valid, nibble}
   function automatic logic [4:0] hexd(input logic [7:0] b);
      logic [7:0] u;
      u = upc(b);
      if (u >= 8'h30 && u <= 8'h39) hexd = {1'b1, u[3:0]};
      else if (u >= 8'h41 && u <= 8'h46) hexd = {1'b1, u[3:0] + 4'h9};
      else hexd = 5'h00;
   endfunction
   // nibble to upper-case ascii hex digit
   function automatic logic [7:0] asc(input logic [3:0] n);
      asc = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction
endpackage
`default_nettype wire

// *** ascii_read_parser.sv ***
// ascii individual-read request parser and response builder
`default_nettype none
module ascii_read_parser (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // own station number
   input wire logic [7:0] i_station,
   // received byte stream
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   output logic o_rx_ready,
   // transmitted byte stream
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   // device memory read port
   output logic o_mem_rd,
   output ascii_read_pkg::dev_t o_mem_dev,
   input wire logic i_mem_ack,
   input wire logic [15:0] i_mem_data
);
   typedef enum logic [4:0] {S_IDLE, S_STN_H, S_STN_L, S_CMD, S_TYP1, S_TYP2, S_CNT_H, S_CNT_L,
      S_LEN_H, S_LEN_L, S_NAME, S_TAIL, S_BCC_H, S_BCC_L, S_DONE,
      T_HEAD, T_ERR, T_CNT, T_RD, T_BLK, T_ETX, T_BCC} state_t;

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_s1_reg, rst_n_reg;
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   state_t st_reg, st_next;
   logic [8:0] cnt_reg, cnt_next;
   logic [7:0] sum_reg, sum_next, tsum_reg, tsum_next, stn_reg, stn_next;
   logic [7:0] txd_reg, txd_next;
   logic txv_reg, txv_next, low_reg, low_next, skip_reg, skip_next;
   logic [15:0] err_reg, err_next, data_reg, data_next;
   logic [4:0] nblk_reg, nblk_next, blk_reg, blk_next, len_reg, len_next, pos_reg, pos_next;
   logic [3:0] hi_reg, hi_next;
   logic [2:0] step_reg, step_next;
   ascii_read_pkg::dev_t cur_reg, cur_next;
   ascii_read_pkg::dev_t tab_reg [16];
   ascii_read_pkg::dev_t tab_next [16];

   // comb locals
   logic [7:0] b, u, nb;
   logic [4:0] h;
   logic [7:0] hv;
   logic [15:0] e;
   logic rx_fire, eot, bcc_st, free, load, legal;
   ascii_read_pkg::dev_t sel;

   assign sel = tab_reg[blk_reg[3:0]];
   assign o_rx_ready = (st_reg < S_DONE);
   assign rx_fire = i_rx_valid && o_rx_ready;
   assign o_tx_valid = txv_reg;
   assign o_tx_data = txd_reg;
   assign o_mem_rd = (st_reg == T_RD);

   // memory request; byte names carry doubled address
   always_comb begin
      o_mem_dev = sel;
      if (sel.width == ascii_read_pkg::W_BYTE) o_mem_dev.addr = {1'b0, sel.addr[15:1]};
   end

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      sum_next = sum_reg;
      tsum_next = tsum_reg;
      stn_next = stn_reg;
      txd_next = txd_reg;
      txv_next = txv_reg;
      low_next = low_reg;
      skip_next = skip_reg;
      err_next = err_reg;
      data_next = data_reg;
      nblk_next = nblk_reg;
      blk_next = blk_reg;
      len_next = len_reg;
      pos_next = pos_reg;
      hi_next = hi_reg;
      step_next = step_reg;
      cur_next = cur_reg;
      tab_next = tab_reg;
      b = i_rx_data;
      u = ascii_read_pkg::upc(b);
      h = ascii_read_pkg::hexd(b);
      hv = {hi_reg, h[3:0]};
      e = ascii_read_pkg::E_NONE;
      eot = 1'b0;
      bcc_st = (st_reg == S_BCC_H) || (st_reg == S_BCC_L);
      legal = (u >= 8'h30 && u <= 8'h39) || (u >= 8'h41 && u <= 8'h5A) || b == ascii_read_pkg::C_PCT;
      nb = 8'h00;
      load = 1'b0;
      free = !txv_reg || i_tx_ready;
      if (txv_reg && i_tx_ready) txv_next = 1'b0;
      // request parsing
      if (rx_fire) begin
         if (st_reg == S_IDLE) begin
            if (b == ascii_read_pkg::C_ENQ) begin
               st_next = S_STN_H;
               cnt_next = 9'h001;
               sum_next = b;
               err_next = ascii_read_pkg::E_NONE;
               skip_next = 1'b0;
               low_next = 1'b0;
            end
         end else begin
            cnt_next = cnt_reg + 9'h001;
            if (!bcc_st) sum_next = sum_reg + b;
            if (cnt_reg == ascii_read_pkg::MAX_FRAME) e = ascii_read_pkg::E_LONG;
            if (b == ascii_read_pkg::C_EOT && !bcc_st) begin
               eot = 1'b1;
               if (st_reg != S_TAIL) e = ascii_read_pkg::E_FRM;
               st_next = low_reg ? S_BCC_H : S_DONE;
            end else begin
               unique case (st_reg)
                  S_STN_H, S_CNT_H, S_LEN_H, S_BCC_H: begin
                     if (!h[4]) e = ascii_read_pkg::E_HEX;
                     hi_next = h[3:0];
                     st_next = state_t'(st_reg + 5'd1);
                  end
                  S_STN_L: begin
                     if (!h[4]) e = ascii_read_pkg::E_HEX;
                     stn_next = hv;
                     if (hv != i_station) skip_next = 1'b1;
                     st_next = S_CMD;
                  end
                  S_CMD: begin
                     if (b == ascii_read_pkg::C_CMD_LO) low_next = 1'b1;
                     else if (b != ascii_read_pkg::C_CMD_UP) e = ascii_read_pkg::E_CMD;
                     st_next = S_TYP1;
                  end
                  S_TYP1, S_TYP2: begin
                     if (u != ascii_read_pkg::C_TYPE) e = ascii_read_pkg::E_CMD;
                     st_next = state_t'(st_reg + 5'd1);
                  end
                  S_CNT_L: begin
                     if (!h[4]) e = ascii_read_pkg::E_HEX;
                     else if (hv == 8'h00 || hv > {3'h0, ascii_read_pkg::MAX_BLK}) e = ascii_read_pkg::E_CNT;
                     nblk_next = hv[4:0];
                     blk_next = 5'h00;
                     st_next = S_LEN_H;
                  end
                  S_LEN_L: begin
                     if (!h[4]) e = ascii_read_pkg::E_HEX;
                     else if (hv == 8'h00 || hv > {3'h0, ascii_read_pkg::MAX_NAME}) e = ascii_read_pkg::E_LEN;
                     len_next = hv[4:0];
                     pos_next = 5'h00;
                     cur_next = '0;
                     st_next = S_NAME;
                  end
                  S_NAME: begin
                     if (!legal) e = ascii_read_pkg::E_NAME;
                     if (pos_reg == 5'h00) begin
                        if (b != ascii_read_pkg::C_PCT) e = ascii_read_pkg::E_NAME;
                     end else if (pos_reg == 5'h01) begin
                        unique case (u)
                           8'h50: cur_next.area = ascii_read_pkg::A_P;
                           8'h4D: cur_next.area = ascii_read_pkg::A_M;
                           8'h4C: cur_next.area = ascii_read_pkg::A_L;
                           8'h4B: cur_next.area = ascii_read_pkg::A_K;
                           8'h43: cur_next.area = ascii_read_pkg::A_C;
                           8'h54: cur_next.area = ascii_read_pkg::A_T;
                           8'h44: cur_next.area = ascii_read_pkg::A_D;
                           8'h53: cur_next.area = ascii_read_pkg::A_S;
                           8'h46: cur_next.area = ascii_read_pkg::A_F; // read-only area, reads only
                           default: e = ascii_read_pkg::E_NAME;
                        endcase
                     end else if (pos_reg == 5'h02) begin
                        if (u == ascii_read_pkg::C_BIT) cur_next.width = ascii_read_pkg::W_BIT;
                        else if (u == ascii_read_pkg::C_BYTE) cur_next.width = ascii_read_pkg::W_BYTE;
                        else if (u == ascii_read_pkg::C_WORD) cur_next.width = ascii_read_pkg::W_WORD;
                        else e = ascii_read_pkg::E_TYPE;
                     end else begin
                        // decimal address digits
                        if (u < 8'h30 || u > 8'h39) e = ascii_read_pkg::E_NAME;
                        cur_next.addr = 16'((cur_reg.addr << 3) + (cur_reg.addr << 1) + {8'h00, b - 8'h30});
                     end
                     pos_next = pos_reg + 5'h01;
                     if (pos_next == len_reg) begin
                        if (len_reg < ascii_read_pkg::MIN_NAME) e = ascii_read_pkg::E_NAME;
                        if ((cur_next.area == ascii_read_pkg::A_D || cur_next.area == ascii_read_pkg::A_S)
                           && cur_next.width == ascii_read_pkg::W_BIT) e = ascii_read_pkg::E_TYPE;
                        tab_next[blk_reg[3:0]] = cur_next;
                        blk_next = blk_reg + 5'h01;
                        st_next = (blk_next == nblk_reg) ? S_TAIL : S_LEN_H;
                     end
                  end
                  S_TAIL: e = ascii_read_pkg::E_FRM;
                  S_BCC_L: begin
                     if (!h[4] || hv != sum_reg) e = ascii_read_pkg::E_BCC;
                     st_next = S_DONE;
                  end
                  default: st_next = S_IDLE;
               endcase
            end
            // first error is kept; remaining bytes are skipped up to the end code
            if (e != ascii_read_pkg::E_NONE) begin
               if (err_reg == ascii_read_pkg::E_NONE) err_next = e;
               if (!eot && !bcc_st && st_reg != S_BCC_L) st_next = S_TAIL;
            end
         end
      end
      // response building
      unique case (st_reg)
         S_DONE: begin
            st_next = skip_reg ? S_IDLE : T_HEAD;
            step_next = 3'h0;
            tsum_next = 8'h00;
            blk_next = 5'h00;
         end
         T_HEAD: begin
            load = free;
            unique case (step_reg)
               3'h0: nb = (err_reg != ascii_read_pkg::E_NONE) ? ascii_read_pkg::C_NAK : ascii_read_pkg::C_ACK;
               3'h1: nb = ascii_read_pkg::asc(stn_reg[7:4]);
               3'h2: nb = ascii_read_pkg::asc(stn_reg[3:0]);
               3'h3: nb = low_reg ? ascii_read_pkg::C_CMD_LO : ascii_read_pkg::C_CMD_UP;
               default: nb = ascii_read_pkg::C_TYPE;
            endcase
            if (load && step_reg == 3'h5) st_next = (err_reg != ascii_read_pkg::E_NONE) ? T_ERR : T_CNT;
         end
         T_ERR: begin
            load = free;
            nb = ascii_read_pkg::asc(4'(err_reg >> {~step_reg[1:0], 2'b00}));
            if (load && step_reg == 3'h3) st_next = T_ETX;
         end
         T_CNT: begin
            load = free;
            nb = (step_reg == 3'h0) ? ascii_read_pkg::asc({3'h0, nblk_reg[4]}) : ascii_read_pkg::asc(nblk_reg[3:0]);
            if (load && step_reg == 3'h1) st_next = T_RD;
         end
         T_RD: begin
            if (i_mem_ack) begin
               unique case (sel.width)
                  ascii_read_pkg::W_BIT: data_next = {15'h0000, i_mem_data[0]}; // contact state
                  ascii_read_pkg::W_BYTE: data_next = sel.addr[0] ? {8'h00, i_mem_data[15:8]} : {8'h00, i_mem_data[7:0]};
                  default: data_next = i_mem_data; // count value for timer and counter
               endcase
               st_next = T_BLK;
            end
         end
         T_BLK: begin
            load = free;
            if (step_reg == 3'h0) nb = ascii_read_pkg::C_ZERO;
            else if (step_reg == 3'h1) nb = (sel.width == ascii_read_pkg::W_WORD) ? 8'h32 : 8'h31;
            else if (sel.width == ascii_read_pkg::W_WORD) nb = ascii_read_pkg::asc(4'(data_reg >> (4'(5 - step_reg) << 2)));
            else nb = ascii_read_pkg::asc(4'(data_reg >> (4'(3 - step_reg) << 2)));
            if (load && step_reg == ((sel.width == ascii_read_pkg::W_WORD) ? 3'h5 : 3'h3)) begin
               blk_next = blk_reg + 5'h01;
               st_next = (blk_next == nblk_reg) ? T_ETX : T_RD;
            end
         end
         T_ETX: begin
            load = free;
            nb = ascii_read_pkg::C_ETX;
            if (load) st_next = low_reg ? T_BCC : S_IDLE;
         end
         T_BCC: begin
            load = free;
            nb = ascii_read_pkg::asc(step_reg[0] ? tsum_reg[3:0] : tsum_reg[7:4]);
            if (load && step_reg == 3'h1) st_next = S_IDLE;
         end
         default: ;
      endcase
      if (load) begin
         txd_next = nb;
         txv_next = 1'b1;
         if (st_reg != T_BCC) tsum_next = tsum_reg + nb;
         step_next = (st_next != st_reg) ? 3'h0 : step_reg + 3'h1;
      end else if (st_reg == T_RD) begin
         step_next = 3'h0;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         st_reg <= S_IDLE;
         cnt_reg <= 9'h000;
         sum_reg <= 8'h00;
         tsum_reg <= 8'h00;
         stn_reg <= 8'h00;
         txd_reg <= 8'h00;
         txv_reg <= 1'b0;
         low_reg <= 1'b0;
         skip_reg <= 1'b0;
         err_reg <= 16'h0000;
         data_reg <= 16'h0000;
         nblk_reg <= 5'h00;
         blk_reg <= 5'h00;
         len_reg <= 5'h00;
         pos_reg <= 5'h00;
         hi_reg <= 4'h0;
         step_reg <= 3'h0;
         cur_reg <= '0;
         for (int i = 0; i < 16; i++) tab_reg[i] <= '0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         sum_reg <= sum_next;
         tsum_reg <= tsum_next;
         stn_reg <= stn_next;
         txd_reg <= txd_next;
         txv_reg <= txv_next;
         low_reg <= low_next;
         skip_reg <= skip_next;
         err_reg <= err_next;
         data_reg <= data_next;
         nblk_reg <= nblk_next;
         blk_reg <= blk_next;
         len_reg <= len_next;
         pos_reg <= pos_next;
         hi_reg <= hi_next;
         step_reg <= step_next;
         cur_reg <= cur_next;
         tab_reg <= tab_next;
      end
   end
endmodule
`default_nettype wire

// *** ascii_read_props.sv ***
// port-level checker for the ascii read parser
`default_nettype none
module ascii_read_props (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // byte streams
   input wire logic o_rx_ready,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   // memory port
   input wire logic o_mem_rd,
   input wire ascii_read_pkg::dev_t o_mem_dev,
   input wire logic i_mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   a_dev_held:
      assert property (o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_dev)) else $error("read dropped early");
   a_read_ends:
      assert property (o_mem_rd && i_mem_ack |=> !o_mem_rd) else $error("read held after ack");
   a_tx_held:
      assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data)) else $error("byte lost");
   // a frame for this station keeps rx closed a second cycle with nothing sent, then its reply opens with ACK or NAK
   a_reply_start:
      assert property ($fell(o_rx_ready) ##1 !o_rx_ready |-> !o_tx_valid ##1 o_tx_valid &&
         o_tx_data inside {8'h06, 8'h15}) else $error("reply does not open");
   a_rx_blocked:
      assert property ($fell(o_rx_ready) ##1 !o_rx_ready |-> !o_rx_ready [*8]) else $error("rx reopened early");
   a_read_quiet:
      assert property (o_mem_rd |-> !o_rx_ready) else $error("read while receiving");
   a_tx_ascii:
      assert property (o_tx_valid |-> o_tx_data inside {8'h03, 8'h06, 8'h15, [8'h30:8'h39], [8'h41:8'h46],
         8'h52, 8'h53, 8'h72}) else $error("bad reply byte");
   a_width_ok:
      assert property (o_mem_rd |-> o_mem_dev.width != 2'h3 && o_mem_dev.area <= ascii_read_pkg::A_F &&
         !(o_mem_dev.width == ascii_read_pkg::W_BIT && o_mem_dev.area inside {ascii_read_pkg::A_D,
         ascii_read_pkg::A_S})) else $error("illegal access width");
endmodule
bind ascii_read_parser ascii_read_props props (.i_clk_sys, .i_nrst, .o_rx_ready, .o_tx_valid, .o_tx_data,
   .i_tx_ready, .o_mem_rd, .o_mem_dev, .i_mem_ack);
`default_nettype wire

// *** mem_model.sv ***
// device memory stand-in answering the parser's read port
`default_nettype none
module mem_model (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // read port
   input wire logic i_rd,
   input wire ascii_read_pkg::dev_t i_dev,
   output logic o_ack,
   output logic [15:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_reg;
   logic slow_reg;
   logic [15:0] junk_reg;
   // ack after zero or two idle cycles, alternating per read
   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ack <= 1'b0;
         wait_reg <= 2'h0;
         slow_reg <= 1'b0;
         junk_reg <= 16'h5A5A;
      end else begin
         junk_reg <= {junk_reg[14:0], ~junk_reg[15]};
         o_ack <= 1'b0;
         if (i_rd && !o_ack) begin
            o_ack <= wait_reg == {slow_reg, 1'b0};
            wait_reg <= wait_reg == {slow_reg, 1'b0} ? 2'h0 : wait_reg + 2'h1;
            slow_reg <= slow_reg ^ (wait_reg == {slow_reg, 1'b0});
         end
      end
   end
   // word holds the count, bit 0 the contact; junk outside the ack cycle
   assign o_data = o_ack ? {i_dev.addr[7:0] ^ 8'h3C, i_dev.addr[7:0] + {4'h0, i_dev.area}} : junk_reg;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the ascii read parser
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys, i_nrst, i_rx_valid, i_tx_ready, o_rx_ready, o_tx_valid, o_mem_rd, i_mem_ack;
   logic [7:0] i_station, i_rx_data, o_tx_data, rsum, esum, stn, cmd, tyc, st;
   logic [15:0] i_mem_data, a;
   ascii_read_pkg::dev_t o_mem_dev;
   logic [7:0] rq[$];
   logic [7:0] ex[$];
   int failures, samples_checked, n;
   int seed = 20228;
   bit bad, rsp;
   ascii_read_parser dut (.i_clk_sys, .i_nrst, .i_station, .i_rx_valid, .i_rx_data, .o_rx_ready, .o_tx_valid,
      .o_tx_data, .i_tx_ready, .o_mem_rd, .o_mem_dev, .i_mem_ack, .i_mem_data);
   mem_model mem (.i_clk_sys, .i_nrst, .i_rd(o_mem_rd), .i_dev(o_mem_dev), .o_ack(i_mem_ack), .o_data(i_mem_data));
   // clock
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   // random sink stalls
   always @(posedge i_clk_sys) i_tx_ready <= |($random(seed) & 3);
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want) begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   // compare each sent reply byte with the oldest note
   always @(posedge i_clk_sys) begin
      if (o_tx_valid === 1'b1 && i_tx_ready) begin
         if (ex.size() == 0) check(o_tx_data, 8'hFF);
         else check(o_tx_data, ex.pop_front());
      end
   end
   task automatic summarize();
      $display("compares %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic step();
      n++;
      if (n > 3000) begin
         failures++;
         summarize();
      end
   endtask
   function automatic logic [7:0] hc(input logic [3:0] v);
      return v < 4'hA ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
   endfunction
   task automatic r(input logic [7:0] v);
      rq.push_back(v);
      rsum += v;
   endtask
   task automatic r2(input logic [7:0] v);
      r(hc(v[7:4]));
      r(hc(v[3:0]));
   endtask
   task automatic e(input logic [7:0] v);
      ex.push_back(v);
      esum += v;
   endtask
   task automatic e2(input logic [7:0] v);
      e(hc(v[7:4]));
      e(hc(v[3:0]));
   endtask
   // request header, and the ack header when a good reply is due
   task automatic open(input logic [7:0] s, input logic [7:0] c, input logic [7:0] cnt, input bit ack);
      rsum = 8'h00;
      esum = 8'h00;
      stn = s;
      cmd = c;
      rsp = ack;
      r(8'h05);
      r2(s);
      r(c);
      r(tyc);
      r(tyc);
      r2(cnt);
      if (ack) begin
         e(8'h06);
         e2(s);
         e(c);
         e(8'h53);
         e(8'h53);
         e2(cnt);
      end
   endtask
   task automatic nak(input logic [15:0] code);
      rsp = 1'b1;
      e(8'h15);
      e2(stn);
      e(cmd);
      e(8'h53);
      e(8'h53);
      e2(code[15:8]);
      e2(code[7:0]);
   endtask
   // one block: name in the request, data of the memory stand-in in the reply
   task automatic dev(input string nm, input ascii_read_pkg::area_t ar, input ascii_read_pkg::width_t w,
      input logic [15:0] ad);
      logic [15:0] m;
      r2(8'(nm.len()));
      for (int i = 0; i < nm.len(); i++) r(nm[i]);
      if (!rsp || ex.size() < 8 || ex[0] != 8'h06) return;
      m = w == ascii_read_pkg::W_BYTE ? ad >> 1 : ad;
      m = {m[7:0] ^ 8'h3C, m[7:0] + {4'h0, ar}};
      e(8'h30);
      e(w == ascii_read_pkg::W_WORD ? 8'h32 : 8'h31);
      if (w == ascii_read_pkg::W_WORD) e2(m[15:8]);
      if (w == ascii_read_pkg::W_BIT) e2({7'h00, m[0]});
      else if (w == ascii_read_pkg::W_BYTE) e2(ad[0] ? m[15:8] : m[7:0]);
      else e2(m[7:0]);
   endtask
   // tail, then send the request byte by byte and await the reply
   task automatic close(input string t);
      logic ok;
      r(8'h04);
      if (cmd == 8'h72) r2(rsum ^ {7'h00, bad});
      if (rsp) e(8'h03);
      if (rsp && cmd == 8'h72) e2(esum);
      i_rx_valid <= 1'b1;
      n = 0;
      while (rq.size() > 0) begin
         i_rx_data <= rq.pop_front();
         do begin
            @(negedge i_clk_sys);
            ok = o_rx_ready;
            @(posedge i_clk_sys);
            step();
         end while (!ok);
      end
      i_rx_valid <= 1'b0;
      do begin
         @(posedge i_clk_sys);
         step();
      end while (ex.size() > 0 || !o_rx_ready);
      repeat (20) @(posedge i_clk_sys);
      bad = 1'b0;
      tyc = 8'h53;
      $display("test done: %s", t);
   endtask
   task automatic refuse(input logic [7:0] c, input logic [7:0] cnt, input string nm, input logic [15:0] code);
      open(8'h20, c, cnt, 1'b0);
      nak(code);
      dev(nm, ascii_read_pkg::A_P, ascii_read_pkg::W_BIT, 16'h0000);
      close(nm);
   endtask
   initial begin
      i_nrst = 1'b0;
      i_rx_valid = 1'b0;
      i_rx_data = 8'h00;
      i_station = 8'h20;
      tyc = 8'h53;
      repeat (10) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      open(8'h20, 8'h52, 8'h03, 1'b1);
      dev("%MW100", ascii_read_pkg::A_M, ascii_read_pkg::W_WORD, 16'h0064);
      dev("%TX7", ascii_read_pkg::A_T, ascii_read_pkg::W_BIT, 16'h0007);
      dev("%DB13", ascii_read_pkg::A_D, ascii_read_pkg::W_BYTE, 16'h000D);
      close("mixed widths");
      open(8'h20, 8'h72, 8'h01, 1'b1);
      dev("%MW100", ascii_read_pkg::A_M, ascii_read_pkg::W_WORD, 16'h0064);
      close("lowercase checksum");
      tyc = 8'h73;
      open(8'h20, 8'h52, 8'h02, 1'b1);
      dev("%cw5", ascii_read_pkg::A_C, ascii_read_pkg::W_WORD, 16'h0005);
      dev("%kb8", ascii_read_pkg::A_K, ascii_read_pkg::W_BYTE, 16'h0008);
      close("letter case");
      open(8'h21, 8'h52, 8'h01, 1'b0);
      dev("%MW1", ascii_read_pkg::A_M, ascii_read_pkg::W_WORD, 16'h0001);
      close("other station");
      refuse(8'h52, 8'h01, "%DX10", 16'h0006);
      refuse(8'h52, 8'h01, "%SX3", 16'h0006);
      refuse(8'h52, 8'h00, "%MW1", 16'h0003);
      refuse(8'h52, 8'h11, "%MW1", 16'h0003);
      refuse(8'h52, 8'h01, "%MW1#", 16'h0005);
      refuse(8'h52, 8'h01, "%MW12345678901234", 16'h0004);
      bad = 1'b1;
      refuse(8'h72, 8'h01, "%MW1", 16'h0008);
      st = 8'($random(seed));
      i_station <= st;
      open(st, 8'h52, 8'h10, 1'b1);
      for (int i = 0; i < 16; i++) begin
         a = 16'($random(seed)) & 16'h03FF;
         dev($sformatf("%%PW%0d", a), ascii_read_pkg::A_P, ascii_read_pkg::W_WORD, a);
      end
      close("sixteen blocks");
      summarize();
   end
endmodule
`default_nettype wire
